// ===== hw/ppc_port_policy.sv
/*
 port policy logic of an eight channel power sourcing controller: remapping,
 fast shutdown priority, converter sequencing and averaging, bus watchdog,
 foldback curve selection and class assignment.
 assumes a 10 MHz clock; shutdown input and bus clock are asynchronous pins.
*/
// Function
// - map ports only within own group
// - drop group remap unless all off
// - invalid remap keeps prior, acked anyway
// - soft reset keeps map, hard resets
// - mask bit selects one or three bit
// - one bit: flagged ports off on high
// - three bit codes, zero highest priority
// - disable when shutdown code <= priority
// - deglitch input, long pulse is start
// - eight current, two shared converters
// - current 100 ms, discovery 16 ms
// - current 800 us, others 1 ms
// - detection averages sixteen samples
// - watchdog sees bus clock edges, resets
// - two seconds idle sets status, latches
// - status clears by reset or zero write
// - code 1011b disables watchdog, preset
// - inrush ignores double foldback bit
// - powered uses 2x or 1x curve
// - per-port alternative curve enables
// - low allocation high class: fault
`include "ppc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ppc_port_policy #(
	parameter int WD_CYC = `PPC_WD_CYC
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic fast_shutdown_input,
	input wire logic bus_scl,
	input wire logic map_write,
	input wire logic [15:0] map_wdata,
	output logic [15:0] map_rdata,
	output logic map_ack,
	input wire logic [7:0] port_off_mode,
	input wire logic multibit_priority_select,
	input wire logic [7:0] port_low_priority_flag,
	input wire logic [23:0] port_priority_code,
	input wire logic [3:0] watchdog_disable,
	input wire logic watchdog_status_clear,
	output logic watchdog_timeout_status,
	output logic bus_reset,
	output logic [7:0] port_shutdown,
	input wire logic [7:0] port_powered,
	input wire logic [7:0] power_good,
	input wire ppc_pkg::ppc_fold_cfg_s [7:0] fold_cfg,
	output ppc_pkg::ppc_curve_s [7:0] curve,
	input wire logic [7:0] cur_sample_valid,
	input wire logic [111:0] cur_sample,
	output logic [7:0] cur_conv_start,
	output logic [1:0] shared_conv_start,
	input wire logic [1:0] shared_sample_valid,
	input wire logic [27:0] shared_sample,
	output logic [111:0] cur_average,
	output logic [27:0] disc_average,
	output logic [1:0] disc_average_valid,
	input wire logic [15:0] port_alloc,
	input wire logic [23:0] requested_class,
	output ppc_pkg::ppc_class_s [7:0] class_result
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a group map is valid when its four 2-bit codes are distinct
	function automatic logic map_ok(input logic [7:0] m);
		map_ok = (m[1:0] != m[3:2]) && (m[1:0] != m[5:4]) && (m[1:0] != m[7:6]) &&
			(m[3:2] != m[5:4]) && (m[3:2] != m[7:6]) && (m[5:4] != m[7:6]);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] oss_sync_q; // shutdown pin sync
	logic [1:0] scl_sync_q; // bus clock sync
	logic scl_last_q; // for edge finding
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			oss_sync_q <= 2'h0;
			scl_sync_q <= 2'h3;
			scl_last_q <= 1'h1;
		end else begin
			oss_sync_q <= {oss_sync_q[0], fast_shutdown_input};
			scl_sync_q <= {scl_sync_q[0], bus_scl};
			scl_last_q <= scl_sync_q[1];
		end
	end
	wire scl_edge = scl_sync_q[1] ^ scl_last_q;

	// ----------------------------------------
	// port remapping
	// ----------------------------------------
	logic [15:0] map_q; // two groups, 2-bit channel per port
	// a group is written only when all four ports are off and codes distinct
	wire grp0_wr = map_write && (&port_off_mode[3:0]) && map_ok(map_wdata[7:0]);
	wire grp1_wr = map_write && (&port_off_mode[7:4]) && map_ok(map_wdata[15:8]);
	// map held by hard reset only; soft reset has no effect here
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			map_q <= {`PPC_MAP_DEFAULT, `PPC_MAP_DEFAULT};
		end else begin
			if (grp0_wr) map_q[7:0] <= map_wdata[7:0];
			if (grp1_wr) map_q[15:8] <= map_wdata[15:8];
		end
	end
	// ack every write regardless of outcome
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) map_ack <= 1'h0;
		else map_ack <= map_write;
	end
	assign map_rdata = map_q;

	// ----------------------------------------
	// shutdown input deglitch and receiver
	// ----------------------------------------
	logic oss_filt_q; // filtered level
	logic [7:0] dg_cnt_q; // deglitch count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			oss_filt_q <= 1'h0;
			dg_cnt_q <= 8'h0;
		end else if (oss_sync_q[1] == oss_filt_q) begin
			dg_cnt_q <= 8'h0;
		end else if (dg_cnt_q == 8'(`PPC_DEGLITCH_CYC - 1)) begin
			oss_filt_q <= oss_sync_q[1];
			dg_cnt_q <= 8'h0;
		end else begin
			dg_cnt_q <= dg_cnt_q + 8'h1;
		end
	end

	ppc_pkg::ppc_rx_e rx_q; // receiver state
	logic [11:0] rx_cnt_q; // bit timing
	logic [1:0] rx_idx_q; // bit index
	logic [2:0] rx_code_q; // received code
	logic [2:0] shut_code_q; // active shutdown code
	logic shut_active_q; // code in force
	// start bit from idle, then three data bits msb first, released on idle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_q <= ppc_pkg::RX_IDLE;
			rx_cnt_q <= 12'h0;
			rx_idx_q <= 2'h0;
			rx_code_q <= 3'h0;
			shut_code_q <= 3'h0;
			shut_active_q <= 1'h0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 12'h1;
			case (rx_q)
				ppc_pkg::RX_IDLE: begin
					rx_cnt_q <= 12'h0;
					if (oss_filt_q) rx_q <= ppc_pkg::RX_START;
				end
				ppc_pkg::RX_START: begin
					if (rx_cnt_q == 12'(`PPC_BIT_CYC + `PPC_BIT_CYC / 2)) begin
						rx_cnt_q <= 12'h0;
						rx_idx_q <= 2'h0;
						rx_q <= ppc_pkg::RX_BITS;
					end
				end
				ppc_pkg::RX_BITS: begin
					if (rx_cnt_q == 12'h0) begin
						rx_code_q <= {rx_code_q[1:0], oss_filt_q};
						rx_idx_q <= rx_idx_q + 2'h1;
					end
					if (rx_cnt_q == 12'(`PPC_BIT_CYC - 1)) rx_cnt_q <= 12'h0;
					if (rx_idx_q == 2'h3) begin
						shut_code_q <= rx_code_q;
						shut_active_q <= 1'h1;
						rx_cnt_q <= 12'h0;
						rx_q <= ppc_pkg::RX_HOLD;
					end
				end
				default: begin
					// wait for a long idle before the next frame
					if (oss_filt_q) rx_cnt_q <= 12'h0;
					else if (rx_cnt_q == 12'(`PPC_IDLE_CYC)) begin
						shut_active_q <= 1'h0;
						rx_q <= ppc_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	logic [31:0] wd_cnt_q; // cycles since last bus clock edge
	logic wd_latch_q; // ports latched off
	wire wd_enabled = (watchdog_disable != `PPC_WD_OFF_CODE);
	wire wd_expire = (wd_cnt_q == 32'(WD_CYC - 1));
	// count idle bus clock, set status even when disabled
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wd_cnt_q <= 32'h0;
			watchdog_timeout_status <= 1'h0;
			wd_latch_q <= 1'h0;
			bus_reset <= 1'h0;
		end else begin
			bus_reset <= wd_expire && wd_enabled;
			if (scl_edge || wd_expire) wd_cnt_q <= 32'h0;
			else wd_cnt_q <= wd_cnt_q + 32'h1;
			// set wins over a clear in the same cycle
			if (wd_expire) watchdog_timeout_status <= 1'h1;
			else if (watchdog_status_clear || soft_reset) watchdog_timeout_status <= 1'h0;
			if (wd_expire && wd_enabled) wd_latch_q <= 1'h1;
			else if (soft_reset) wd_latch_q <= 1'h0;
		end
	end

	// ----------------------------------------
	// per-port shutdown, curves, class
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < 8; p++) begin : g_port
			wire [2:0] prio = port_priority_code[3*p +: 3];
			wire single_off = oss_filt_q && port_low_priority_flag[p];
			wire multi_off = shut_active_q && (shut_code_q <= prio);
			wire [1:0] alloc = port_alloc[2*p +: 2];
			wire [2:0] req = requested_class[3*p +: 3];
			wire low_alloc = (alloc == `PPC_ALLOC_4W) || (alloc == `PPC_ALLOC_7W);
			wire too_big = low_alloc && (req >= `PPC_CLASS_3);
			wire [2:0] cap = (alloc == `PPC_ALLOC_15W) ? `PPC_CLASS_3 :
				(alloc == `PPC_ALLOC_30W) ? `PPC_CLASS_MAX : `PPC_CLASS_2;
			wire [2:0] asg = (req > cap) ? cap : req;
			wire inrush = port_powered[p] && !power_good[p];
			// shutdown, curve and class registers
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					port_shutdown[p] <= 1'h0;
					curve[p] <= '0;
					class_result[p] <= '0;
				end else begin
					port_shutdown[p] <= wd_latch_q || (multibit_priority_select ? multi_off : single_off);
					curve[p].inrush <= inrush;
					curve[p].use_2x <= !inrush && fold_cfg[p].double_foldback_select;
					curve[p].alt <= inrush ? fold_cfg[p].alt_inrush_curve_enable :
						fold_cfg[p].alt_operational_curve_enable;
					class_result[p].assigned_class <= too_big ? 3'h0 : asg;
					class_result[p].start_fault <= too_big;
					class_result[p].insufficient_power <= too_big;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// converters
	// ----------------------------------------
	logic [13:0] iconv_cnt_q; // current conversion period
	logic [13:0] vconv_cnt_q; // shared conversion period
	wire iconv_tick = (iconv_cnt_q == 14'(`PPC_ICONV_CYC - 1));
	wire vconv_tick = (vconv_cnt_q == 14'(`PPC_VCONV_CYC - 1));
	// conversion pacing for all ten converters
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			iconv_cnt_q <= 14'h0;
			vconv_cnt_q <= 14'h0;
			cur_conv_start <= 8'h0;
			shared_conv_start <= 2'h0;
		end else begin
			iconv_cnt_q <= iconv_tick ? 14'h0 : iconv_cnt_q + 14'h1;
			vconv_cnt_q <= vconv_tick ? 14'h0 : vconv_cnt_q + 14'h1;
			cur_conv_start <= {8{iconv_tick}} & port_powered;
			shared_conv_start <= {2{vconv_tick}};
		end
	end

	// per-channel current average over 125 samples of 800 us
	generate
		for (p = 0; p < 8; p++) begin : g_iavg
			logic [20:0] acc_q;
			logic [6:0] n_q;
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					acc_q <= 21'h0;
					n_q <= 7'h0;
					cur_average[14*p +: 14] <= 14'h0;
				end else if (!port_powered[p]) begin
					acc_q <= 21'h0;
					n_q <= 7'h0;
				end else if (cur_sample_valid[p]) begin
					if (n_q == 7'(`PPC_IAVG_N - 1)) begin
						cur_average[14*p +: 14] <= 14'((acc_q + 21'(cur_sample[14*p +: 14])) /
							21'(`PPC_IAVG_N));
						acc_q <= 21'h0;
						n_q <= 7'h0;
					end else begin
						acc_q <= acc_q + 21'(cur_sample[14*p +: 14]);
						n_q <= n_q + 7'h1;
					end
				end
			end
		end
		// shared converter discovery average of sixteen samples
		for (p = 0; p < 2; p++) begin : g_davg
			logic [17:0] acc_q;
			logic [3:0] n_q;
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					acc_q <= 18'h0;
					n_q <= 4'h0;
					disc_average[14*p +: 14] <= 14'h0;
					disc_average_valid[p] <= 1'h0;
				end else begin
					disc_average_valid[p] <= 1'h0;
					if (shared_sample_valid[p]) begin
						if (n_q == 4'(`PPC_DISC_N - 1)) begin
							disc_average[14*p +: 14] <= 14'((acc_q + 18'(shared_sample[14*p +: 14])) /
								18'(`PPC_DISC_N));
							disc_average_valid[p] <= 1'h1;
							acc_q <= 18'h0;
							n_q <= 4'h0;
						end else begin
							acc_q <= acc_q + 18'(shared_sample[14*p +: 14]);
							n_q <= n_q + 4'h1;
						end
					end
				end
			end
		end
	endgenerate

endmodule // ppc_port_policy

`default_nettype wire

// ===== hw/ppc_map.svh
/*
 constants for the port policy control block: reset values, codes, timing counts.
 assumes a 10 MHz system clock and inclusion by bare name.
*/
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PPC_CLK_KHZ 10000
`define PPC_DEGLITCH_MIN_NS 1000
`define PPC_DEGLITCH_NS 5000
`define PPC_DEGLITCH_CYC ((`PPC_DEGLITCH_NS * `PPC_CLK_KHZ) / 1000000)
`define PPC_BIT_NS 24000
`define PPC_BIT_CYC ((`PPC_BIT_NS * `PPC_CLK_KHZ) / 1000000)
`define PPC_IDLE_US 200
`define PPC_IDLE_CYC ((`PPC_IDLE_US * `PPC_CLK_KHZ) / 1000)
`define PPC_ICONV_US 800
`define PPC_ICONV_CYC ((`PPC_ICONV_US * `PPC_CLK_KHZ) / 1000)
`define PPC_VCONV_US 1000
`define PPC_VCONV_CYC ((`PPC_VCONV_US * `PPC_CLK_KHZ) / 1000)
`define PPC_WD_MS 2000
`define PPC_WD_CYC (`PPC_WD_MS * `PPC_CLK_KHZ)
`define PPC_IAVG_MS 100
`define PPC_IAVG_N 125
`define PPC_DISC_N 16

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define PPC_WD_OFF_CODE 4'hb
`define PPC_MAP_DEFAULT 8'he4
`define PPC_ALLOC_4W 2'h0
`define PPC_ALLOC_7W 2'h1
`define PPC_ALLOC_15W 2'h2
`define PPC_ALLOC_30W 2'h3
`define PPC_CLASS_MAX 3'h4
`define PPC_CLASS_3 3'h3
`define PPC_CLASS_2 3'h2

`endif

// ===== hw/ppc_pkg.sv
/*
 types shared by the port policy control block.
 assumes the map header for constants.
*/
package ppc_pkg;
	// per-port foldback selection group
	typedef struct packed {
		logic double_foldback_select;
		logic alt_inrush_curve_enable;
		logic alt_operational_curve_enable;
	} ppc_fold_cfg_s;
	// analog curve selection handed to the channel
	typedef struct packed {
		logic inrush;
		logic use_2x;
		logic alt;
	} ppc_curve_s;
	// shutdown receiver states
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_HOLD} ppc_rx_e;
	// classification result group
	typedef struct packed {
		logic [2:0] assigned_class;
		logic start_fault;
		logic insufficient_power;
	} ppc_class_s;
endpackage

// ===== test/ppc_port_policy_properties.sv
/*
 checker for the port policy block, bound to its ports.
 assumes the design package is compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module ppc_port_policy_properties #(
	parameter int WD_CYC = 200
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic map_write,
	input wire logic [15:0] map_rdata,
	input wire logic map_ack,
	input wire logic multibit_priority_select,
	input wire logic [7:0] port_low_priority_flag,
	input wire logic [3:0] watchdog_disable,
	input wire logic watchdog_status_clear,
	input wire logic watchdog_timeout_status,
	input wire logic bus_reset,
	input wire logic [7:0] port_shutdown,
	input wire logic [7:0] port_powered,
	input wire logic [7:0] power_good,
	input wire ppc_pkg::ppc_fold_cfg_s [7:0] fold_cfg,
	input wire ppc_pkg::ppc_curve_s [7:0] curve,
	input wire logic [15:0] port_alloc,
	input wire logic [23:0] requested_class,
	input wire ppc_pkg::ppc_class_s [7:0] class_result
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// true when the four codes of a group are all different
	function automatic logic perm(input logic [7:0] g);
		return ((4'h1 << g[1:0]) | (4'h1 << g[3:2]) | (4'h1 << g[5:4]) | (4'h1 << g[7:6])) == 4'hf;
	endfunction
	// ----
	// map, shutdown, watchdog
	// ----
	a_map_ack: assert property (map_write |=> map_ack)
		else $error("map write not acknowledged");
	a_map_hold: assert property (!map_ack |-> $stable(map_rdata))
		else $error("map changed without a write");
	a_map_group: assert property (perm(map_rdata[7:0]) && perm(map_rdata[15:8]))
		else $error("map left its group");
	a_flag_only: assert property (!multibit_priority_select && watchdog_disable == 4'hb && !soft_reset
		|=> (port_shutdown & ~$past(port_low_priority_flag)) == 8'h00)
		else $error("unflagged port shut down");
	a_wd_clear: assert property ($fell(watchdog_timeout_status)
		|-> $past(watchdog_status_clear) || $past(soft_reset))
		else $error("watchdog status cleared by itself");
	a_wd_off: assert property (bus_reset |-> $past(watchdog_disable) != 4'hb)
		else $error("bus reset while watchdog disabled");
	a_wd_pulse: assert property (bus_reset |=> !bus_reset && watchdog_timeout_status)
		else $error("bus reset not a single pulse with status");
	// ----
	// curves and classes
	// ----
	a_inrush: assert property (port_powered[0] && !power_good[0] |=> curve[0].inrush
		&& curve[0].alt == $past(fold_cfg[0].alt_inrush_curve_enable))
		else $error("inrush curve wrong");
	a_oper: assert property (port_powered[0] && power_good[0] |=> !curve[0].inrush
		&& curve[0].use_2x == $past(fold_cfg[0].double_foldback_select)
		&& curve[0].alt == $past(fold_cfg[0].alt_operational_curve_enable))
		else $error("operational curve wrong");
	a_low_fault: assert property (port_alloc[1:0] <= 2'h1 && requested_class[2:0] >= 3'h3
		|=> class_result[0].start_fault && class_result[0].insufficient_power)
		else $error("low allocation fault missing");
	a_cap_30w: assert property (port_alloc[1:0] == 2'h3 |=> class_result[0].assigned_class
		== ($past(requested_class[2:0]) > 3'h4 ? 3'h4 : $past(requested_class[2:0])))
		else $error("class cap wrong");
endmodule // ppc_port_policy_properties

bind ppc_port_policy ppc_port_policy_properties #(.WD_CYC(WD_CYC)) ppc_port_policy_properties_i (.*);
`default_nettype wire

// ===== test/ppc_far_end.sv
/*
 far end model: system shutdown source and host bus clock.
 assumes the bench calls its tasks; times in ns.
*/
`timescale 1ns/1ps
`default_nettype none

module ppc_far_end (
	output logic shutdown_pin,
	output logic scl_pin
);
	logic scl_run; // bus clock runs only inside transfers
	initial begin
		shutdown_pin = 1'b0;
		scl_pin = 1'b1;
		scl_run = 1'b0;
	end
	// 800 ns bus clock, pulled high when idle
	always #400 scl_pin = scl_run ? ~scl_pin : 1'b1;
	// host traffic for n clock periods
	task automatic bus(input int n);
		scl_run = 1'b1;
		#(n * 800);
		scl_run = 1'b0;
	endtask
	// plain level for the one-bit scheme
	task automatic level(input logic v);
		shutdown_pin = v;
	endtask
	// pulse too short to pass the filter
	task automatic glitch();
		shutdown_pin = 1'b1;
		#500;
		shutdown_pin = 1'b0;
	endtask
	// start bit, code msb first, then idle long enough to release
	task automatic frame(input logic [2:0] code);
		shutdown_pin = 1'b1;
		#24000;
		for (int i = 2; i >= 0; i--) begin
			shutdown_pin = code[i];
			#24000;
		end
		shutdown_pin = 1'b0;
		#200000;
	endtask
endmodule // ppc_far_end
`default_nettype wire

// ===== test/ppc_port_policy_tb.sv
/*
 self-checking bench for the port policy block.
 assumes design, checker and far end model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module ppc_port_policy_tb;
	localparam int WD = 200; // shortened watchdog count
	logic clock, reset_n, soft_reset, map_write, map_ack, multibit_priority_select;
	logic watchdog_status_clear, watchdog_timeout_status, bus_reset;
	logic [15:0] map_wdata, map_rdata, port_alloc;
	logic [7:0] port_off_mode, port_low_priority_flag, port_shutdown, port_powered, power_good;
	logic [23:0] port_priority_code, requested_class;
	logic [3:0] watchdog_disable;
	wire logic fast_shutdown_input, bus_scl;
	ppc_pkg::ppc_fold_cfg_s [7:0] fold_cfg;
	ppc_pkg::ppc_curve_s [7:0] curve;
	ppc_pkg::ppc_class_s [7:0] class_result;
	logic [7:0] cur_sample_valid, cur_conv_start; // current converter side
	logic [1:0] shared_sample_valid, shared_conv_start, disc_average_valid; // shared side
	logic [111:0] cur_sample, cur_average;
	logic [27:0] shared_sample, disc_average;
	int bus_reset_count = 0; // bus reset pulses seen
	int n_mismatch = 0;
	int comparisons = 0;
	// table row: inputs, then expected class result
	typedef struct packed {
		logic [1:0] alloc;
		logic [2:0] req;
		logic pwr;
		logic pg;
		ppc_pkg::ppc_fold_cfg_s fold;
		ppc_pkg::ppc_class_s exp;
		ppc_pkg::ppc_curve_s cv; // expected curve: inrush, 2x, alt
	} ppc_row_s;
	localparam ppc_row_s ROWS [9] = '{'{2'h0, 3'h1, 1'h1, 1'h0, 3'h7, 5'h04, 3'h5},
		'{2'h1, 3'h2, 1'h1, 1'h1, 3'h5, 5'h08, 3'h3},
		'{2'h1, 3'h3, 1'h1, 1'h1, 3'h3, 5'h03, 3'h1},
		'{2'h0, 3'h7, 1'h1, 1'h0, 3'h4, 5'h03, 3'h4},
		'{2'h2, 3'h4, 1'h1, 1'h1, 3'h6, 5'h0c, 3'h2},
		'{2'h2, 3'h2, 1'h0, 1'h0, 3'h0, 5'h08, 3'h0},
		'{2'h3, 3'h5, 1'h1, 1'h1, 3'h1, 5'h10, 3'h1},
		'{2'h3, 3'h4, 1'h1, 1'h0, 3'h2, 5'h10, 3'h5},
		'{2'h3, 3'h1, 1'h1, 1'h1, 3'h7, 5'h04, 3'h3}};

	ppc_port_policy #(.WD_CYC(WD)) ppc_port_policy_i (.*);
	ppc_far_end ppc_far_end_i (.shutdown_pin(fast_shutdown_input), .scl_pin(bus_scl));

	// ----
	// tasks
	// ----
	always #50 clock = ~clock;
	// count bus reset pulses where they stand
	always @(negedge clock) begin
		if (bus_reset === 1'b1)
			bus_reset_count++;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask
	// bounded wait for a shutdown pattern
	task automatic wait_sd(input logic [7:0] e);
		int k;
		for (k = 0; k < 4000 && port_shutdown !== e; k++)
			@(negedge clock);
		chk("port_shutdown", {8'h00, e}, {8'h00, port_shutdown});
		if (k == 4000)
			print_verdict();
	endtask
	task automatic wr(input logic [15:0] v);
		map_write = 1'b1;
		map_wdata = v;
		@(negedge clock);
		chk("map_ack", 16'h1, {15'h0, map_ack});
		map_write = 1'b0;
		@(negedge clock);
	endtask
	// bounded count of cycles between two conversion start pulses
	task automatic gap(input logic sel, input int want);
		int k;
		int t;
		t = -1;
		for (k = 0; k < 2 * want + 10; k++) begin
			@(negedge clock);
			if (sel ? (shared_conv_start !== 2'h0) : (cur_conv_start !== 8'h00)) begin
				if (t >= 0)
					break;
				t = k;
			end
		end
		chk("conv_gap", 16'(want), (k < 2 * want + 10) ? 16'(k - t) : 16'h0);
		if (k == 2 * want + 10)
			print_verdict();
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		int c;
		clock = 1'b0;
		{reset_n, soft_reset, map_write, multibit_priority_select, watchdog_status_clear} = 5'h00;
		{map_wdata, port_alloc, port_priority_code, requested_class} = 80'h0;
		{port_off_mode, port_low_priority_flag, port_powered, power_good} = 32'h0;
		fold_cfg = 24'h0;
		{cur_sample_valid, shared_sample_valid} = 10'h0;
		cur_sample = 112'h0;
		shared_sample = 28'h0;
		watchdog_disable = 4'hb;
		do_reset();
		chk("map_rdata", 16'he4e4, map_rdata);
		for (int r = 0; r < 9; r++) begin
			port_alloc = {8{ROWS[r].alloc}};
			requested_class = {8{ROWS[r].req}};
			{port_powered, power_good} = {{8{ROWS[r].pwr}}, {8{ROWS[r].pg}}};
			fold_cfg = {8{ROWS[r].fold}};
			@(negedge clock);
			chk("class_result", {11'h0, ROWS[r].exp}, {11'h0, class_result[3]});
			chk("curve", {13'h0, ROWS[r].cv}, {13'h0, curve[3]});
		end
		$display("test table done");
		port_off_mode = 8'hff;
		wr(16'h3939);
		chk("map_rdata", 16'h3939, map_rdata);
		wr(16'h1b00);
		chk("map_rdata", 16'h1b39, map_rdata);
		port_off_mode = 8'hfe;
		wr(16'he4e4);
		chk("map_rdata", 16'he439, map_rdata);
		$display("test remap done");
		repeat (WD + 50) @(negedge clock);
		chk("wd_status", 16'h1, {15'h0, watchdog_timeout_status});
		chk("port_shutdown", 16'h0, {8'h0, port_shutdown});
		fork
			ppc_far_end_i.bus(40);
		join_none
		repeat (10) @(negedge clock);
		{watchdog_status_clear, watchdog_disable} = 5'h10;
		@(negedge clock);
		watchdog_status_clear = 1'b0;
		repeat (290) @(negedge clock);
		chk("wd_status", 16'h0, {15'h0, watchdog_timeout_status});
		wait_sd(8'hff);
		chk("bus_reset", 16'h1, 16'(bus_reset_count));
		{soft_reset, watchdog_disable} = 5'h1b;
		@(negedge clock);
		soft_reset = 1'b0;
		@(negedge clock);
		chk("map_rdata", 16'he439, map_rdata);
		chk("port_shutdown", 16'h0, {8'h0, port_shutdown});
		$display("test watchdog done");
		do_reset();
		chk("map_rdata", 16'he4e4, map_rdata);
		repeat (2100) @(negedge clock);
		multibit_priority_select = 1'b1;
		port_priority_code = 24'hfac688;
		for (c = 0; c < 8; c += 3) begin
			fork
				ppc_far_end_i.frame(c[2:0]);
				wait_sd(8'hff << c);
			join
			wait_sd(8'h00);
		end
		$display("test three-bit done");
		multibit_priority_select = 1'b0;
		port_low_priority_flag = 8'h5a;
		ppc_far_end_i.glitch();
		repeat (100) @(negedge clock);
		chk("port_shutdown", 16'h0, {8'h0, port_shutdown});
		ppc_far_end_i.level(1'b1);
		wait_sd(8'h5a);
		ppc_far_end_i.level(1'b0);
		$display("test one-bit done");
		// discovery average, sixteen samples on both shared converters
		for (int k = 0; k < 16; k++) begin
			shared_sample = {14'h3fff, 14'(4 * k)};
			shared_sample_valid = 2'h3;
			@(negedge clock);
		end
		shared_sample_valid = 2'h0;
		chk("disc_average_valid", 16'h3, {14'h0, disc_average_valid});
		chk("disc_average", 16'h001e, {2'h0, disc_average[13:0]});
		chk("disc_average", 16'h3fff, {2'h0, disc_average[27:14]});
		// current average over 125 samples on every powered channel
		port_powered = 8'hff;
		for (int k = 0; k < 125; k++) begin
			cur_sample = {8{14'(k)}};
			cur_sample_valid = 8'hff;
			@(negedge clock);
		end
		cur_sample_valid = 8'h00;
		chk("cur_average", 16'h003e, {2'h0, cur_average[13:0]});
		chk("cur_average", 16'h003e, {2'h0, cur_average[111:98]});
		// conversion pacing, starts only on powered channels
		port_powered = 8'h96;
		gap(1'b0, 8000);
		chk("cur_conv_start", {8'h00, port_powered}, {8'h00, cur_conv_start});
		gap(1'b1, 10000);
		chk("shared_conv_start", 16'h3, {14'h0, shared_conv_start});
		$display("test converters done");
		print_verdict();
	end
endmodule // ppc_port_policy_tb
`default_nettype wire
